// *** jtf_defs.svh ***
`ifndef JTF_DEFS_SVH
`define JTF_DEFS_SVH

// ****************************************
// Field widths, reset values, codes
// ****************************************
`define JTF_LANES 4
`define JTF_K_DEFAULT 6'h20
`define JTF_F_DEFAULT 5'h04
`define JTF_M_DEFAULT 4'h2
`define JTF_NP_DEFAULT 5'h10
`define JTF_ILAS_MF 3'h4
`define JTF_CHAR_K 8'hBC
`define JTF_CHAR_R 8'h1C
`define JTF_CHAR_A 8'h7C
`define JTF_CHAR_Q 8'h9C
`define JTF_CHECKER 8'h55
`define JTF_TOGGLE_HI 8'hFF
`define JTF_SCR_SEED 15'h7FFF
`define JTF_PRBS_SEED 31'h7FFFFFFF

// ****************************************
// Timing
// ****************************************
`define JTF_CLK_MHZ 200
`define JTF_INT_REF_NS 640
`define JTF_INT_REF_CYC ((`JTF_INT_REF_NS * `JTF_CLK_MHZ) / 1000)

`endif

// *** jtf_pkg.sv ***
package jtf_pkg;

  // Framer configuration set applied at initialisation
  typedef struct packed {
    logic link_standard_select;
    logic [3:0] link_bank_ident;
    logic [7:0] link_device_ident;
    logic [4:0] first_lane_ident;
    logic [3:0] converter_count;
    logic [5:0] frames_per_multiframe;
    logic [4:0] octets_per_frame;
    logic [4:0] bits_per_sample;
    logic [7:0] multiblocks_per_extended;
    logic scramble_en;
    logic sysref_source_sel;
    logic [3:0] lane_enable_mask;
    logic [7:0] lane_route_map;
    logic manual_lane_route_en;
    logic [4:0] multiframe_phase_offset;
    logic [1:0] sync_request_input_sel;
    logic oversample_sel;
    logic sync_pad_differential_en;
    logic sync_pad_polarity_inv;
    logic relink_needs_new_ref;
    logic startup_ref_required;
    logic ref_edge_skip_en;
    logic [3:0] ref_edge_select_count;
    logic ref_ignore_when_up;
  } jtf_cfg_s;

  // Test data sources
  typedef enum logic [3:0] {
    TS_NORMAL = 4'h0,
    TS_CHECKER = 4'h1,
    TS_TOGGLE = 4'h2,
    TS_PRBS31 = 4'h3,
    TS_PRBS23 = 4'h4,
    TS_PRBS15 = 4'h5,
    TS_PRBS9 = 4'h6,
    TS_PRBS7 = 4'h7,
    TS_RAMP = 4'h8,
    TS_CUSTOM_PATTERN_REPEAT = 4'h9,
    TS_CUSTOM_PATTERN_SINGLE = 4'hA
  } jtf_test_e;

  // Link states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT_REF = 3'b001,
    ST_CGS = 3'b010,
    ST_ILAS = 3'b011,
    ST_DATA = 3'b100,
    ST_TEST = 3'b101
  } jtf_state_e;

  // Four lanes of one octet each
  typedef logic [3:0][7:0] jtf_lanes_t;

endpackage

// *** jtf_prbs_gen.sv ***
`timescale 1ns/10ps
`default_nettype none

module jtf_prbs_gen
  import jtf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire jtf_test_e order_sel,
  output logic [7:0] prbs_octet
);
`include "jtf_defs.svh"

  logic [30:0] lfsr_r;
  logic [30:0] lfsr_nxt;
  logic [7:0] oct_r;
  logic [7:0] oct_nxt;

  // ****************************************
  // Eight LFSR steps per clock
  // ****************************************
  always_comb
  begin
    logic fb;
    fb = 1'b0;
    lfsr_nxt = lfsr_r;
    oct_nxt = oct_r;
    if (run)
    begin
      for (int i = 0; i < 8; i++)
      begin
        unique case (order_sel)
          TS_PRBS7: fb = lfsr_nxt[6] ^ lfsr_nxt[5];
          TS_PRBS9: fb = lfsr_nxt[8] ^ lfsr_nxt[4];
          TS_PRBS15: fb = lfsr_nxt[14] ^ lfsr_nxt[13];
          TS_PRBS23: fb = lfsr_nxt[22] ^ lfsr_nxt[17];
          default: fb = lfsr_nxt[30] ^ lfsr_nxt[27];
        endcase
        lfsr_nxt = {lfsr_nxt[29:0], fb};
        oct_nxt = {oct_nxt[6:0], fb};
      end
    end
  end

  // Generator registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lfsr_r <= `JTF_PRBS_SEED;
      oct_r <= 8'h00;
    end
    else
    begin
      lfsr_r <= lfsr_nxt;
      oct_r <= oct_nxt;
    end
  end

  assign prbs_octet = oct_r;

endmodule

`default_nettype wire

// *** jtf_framer.sv ***
`timescale 1ns/10ps
`default_nettype none

module jtf_framer
  import jtf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic framer_init,
  input wire jtf_cfg_s cfg_in,
  input wire logic [2:0] sync_single_in,
  input wire logic [2:0] sync_diff_in,
  input wire logic sysref_ext_in,
  input wire logic [31:0] sample_data,
  input wire logic sample_valid,
  input wire jtf_test_e test_source,
  input wire logic [15:0] custom_pattern,
  output jtf_lanes_t lane_data,
  output logic [3:0] lane_is_ctrl,
  output logic link_up,
  output logic ref_locked,
  output logic cfg_invalid
);
`include "jtf_defs.svh"

  // ****************************************
  // Declarations
  // ****************************************
  jtf_cfg_s cfg_r, cfg_nxt;
  logic bad_r, bad_nxt;
  jtf_state_e st_r, st_nxt;
  logic [2:0] sync_m_r, sync_s_r;
  logic [1:0] ref_m_r;
  logic ref_s_r, ref_d_r;
  logic [15:0] iref_r, iref_nxt;
  logic [3:0] edge_r, edge_nxt;
  logic ref_seen_r, ref_seen_nxt;
  logic relink_r, relink_nxt;
  logic [4:0] oct_r, oct_nxt;
  logic [5:0] frm_r, frm_nxt;
  logic [2:0] mfc_r, mfc_nxt;
  logic [31:0] hold_r, hold_nxt, prev_r, prev_nxt;
  logic [3:0][14:0] scr_r, scr_nxt;
  logic [7:0] tcnt_r, tcnt_nxt;
  logic once_r, once_nxt;
  jtf_test_e tsrc_r, tsrc_nxt;
  jtf_lanes_t out_r, out_nxt;
  logic [3:0] ctl_r, ctl_nxt;
  logic [7:0] prbs_oct;
  logic sync_req, ref_pulse, ref_raw, mf_end, cfg_ok;

  // Octet scrambler, polynomial 1 + x^14 + x^15
  function automatic logic [22:0] scr8(input logic [14:0] st, input logic [7:0] d);
    logic [14:0] s;
    logic [7:0] o;
    s = st;
    o = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      o[i] = d[i] ^ s[13] ^ s[14];
      s = {s[13:0], o[i]};
    end
    return {s, o};
  endfunction

  // ****************************************
  // Configuration check and capture
  // ****************************************
  always_comb
  begin
    logic [8:0] fk;
    fk = 9'(cfg_in.octets_per_frame * cfg_in.frames_per_multiframe);
    cfg_ok = 1'b1;
    if (!(cfg_in.converter_count inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8}))
      cfg_ok = 1'b0;
    // K range and F times K
    if (cfg_in.frames_per_multiframe == 6'h00 || cfg_in.frames_per_multiframe > 6'h20
        || fk[1:0] != 2'b00)
      cfg_ok = 1'b0;
    if (!(cfg_in.octets_per_frame inside {5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08,
        5'h0C, 5'h10}))
      cfg_ok = 1'b0;
    if (!(cfg_in.bits_per_sample inside {5'h0C, 5'h10, 5'h18}))
      cfg_ok = 1'b0;
    if ({1'b0, cfg_in.multiframe_phase_offset} >= cfg_in.frames_per_multiframe)
      cfg_ok = 1'b0;
    // sync select limited to three inputs
    if (cfg_in.sync_request_input_sel == 2'h3)
      cfg_ok = 1'b0;
    cfg_nxt = cfg_r;
    bad_nxt = bad_r;
    if (framer_init)
    begin
      bad_nxt = !cfg_ok;
      if (cfg_ok)
        cfg_nxt = cfg_in;
    end
  end

  // ****************************************
  // Input synchronisers and reference source
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sync_m_r <= 3'h0;
      sync_s_r <= 3'h0;
      ref_m_r <= 2'h0;
      ref_s_r <= 1'b0;
      ref_d_r <= 1'b0;
    end
    else
    begin
      sync_m_r <= sync_single_in;
      sync_s_r <= sync_m_r;
      ref_m_r <= {ref_m_r[0], sysref_ext_in};
      ref_s_r <= ref_raw;
      ref_d_r <= ref_s_r;
    end
  end

  // Internal reference pulse counter
  always_comb
  begin
    iref_nxt = (iref_r == 16'(`JTF_INT_REF_CYC - 1)) ? 16'h0000 : iref_r + 16'h0001;
    ref_raw = cfg_r.sysref_source_sel ? ref_m_r[1] : (iref_r == 16'h0000);
    ref_pulse = ref_s_r && !ref_d_r;
  end

  // Differential path goes through its own two stages
  logic [2:0] dif_m_r, dif_s_r;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dif_m_r <= 3'h0;
      dif_s_r <= 3'h0;
    end
    else
    begin
      dif_m_r <= sync_diff_in;
      dif_s_r <= dif_m_r;
    end
  end

  // Sync request selection, active low request
  always_comb
  begin
    logic lvl;
    lvl = cfg_r.sync_pad_differential_en
        ? (dif_s_r[cfg_r.sync_request_input_sel] ^ cfg_r.sync_pad_polarity_inv)
        : sync_s_r[cfg_r.sync_request_input_sel];
    sync_req = !lvl;
  end

  // ****************************************
  // Reference qualification and phase counters
  // ****************************************
  always_comb
  begin
    logic take;
    take = 1'b0;
    edge_nxt = edge_r;
    ref_seen_nxt = ref_seen_r;
    relink_nxt = relink_r;
    oct_nxt = oct_r;
    frm_nxt = frm_r;
    mf_end = (oct_r == cfg_r.octets_per_frame - 5'h01)
        && (frm_r == cfg_r.frames_per_multiframe - 6'h01);
    if (oct_r >= cfg_r.octets_per_frame - 5'h01)
    begin
      oct_nxt = 5'h00;
      frm_nxt = (frm_r >= cfg_r.frames_per_multiframe - 6'h01) ? 6'h00 : frm_r + 6'h01;
    end
    else
      oct_nxt = oct_r + 5'h01;
    if (framer_init)
    begin
      ref_seen_nxt = 1'b0;
      edge_nxt = 4'h0;
      relink_nxt = 1'b0;
    end
    // drop of link may demand a new reference
    if (st_r == ST_DATA && sync_req && !cfg_r.link_standard_select
        && cfg_r.relink_needs_new_ref)
    begin
      ref_seen_nxt = 1'b0;
      edge_nxt = 4'h0;
      relink_nxt = 1'b1;
    end
    if (ref_pulse && !(cfg_r.ref_ignore_when_up && st_r == ST_DATA))
    begin
      if (cfg_r.ref_edge_skip_en && edge_r != cfg_r.ref_edge_select_count)
        edge_nxt = edge_r + 4'h1;
      else
        take = 1'b1;
    end
    if (take)
    begin
      // Set wins over any clear in the same cycle
      ref_seen_nxt = 1'b1;
      relink_nxt = 1'b0;
      oct_nxt = 5'h00;
      frm_nxt = {1'b0, cfg_r.multiframe_phase_offset};
    end
  end

  // ****************************************
  // Link state machine
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    mfc_nxt = mfc_r;
    unique case (st_r)
      ST_IDLE:
        if (framer_init && cfg_ok)
          st_nxt = ST_WAIT_REF;
      ST_WAIT_REF:
        if (ref_seen_r || (!cfg_r.startup_ref_required && !relink_r))
          // C flow has no code group phase
          st_nxt = cfg_r.link_standard_select ? ST_DATA : ST_CGS;
      ST_CGS:
        if (!sync_req && mf_end && ref_seen_r)
        begin
          st_nxt = ST_ILAS;
          mfc_nxt = 3'h0;
        end
      ST_ILAS:
        if (mf_end)
        begin
          mfc_nxt = mfc_r + 3'h1;
          if (mfc_r == `JTF_ILAS_MF - 3'h1)
            st_nxt = ST_DATA;
        end
      ST_DATA:
        if (sync_req && !cfg_r.link_standard_select)
          st_nxt = cfg_r.relink_needs_new_ref ? ST_WAIT_REF : ST_CGS;
      ST_TEST:
        if (test_source == TS_NORMAL)
          st_nxt = ST_WAIT_REF;
    endcase
    if (test_source != TS_NORMAL && st_r != ST_IDLE)
      st_nxt = ST_TEST;
    if (framer_init)
      st_nxt = cfg_ok ? ST_WAIT_REF : ST_IDLE;
  end

  // ****************************************
  // Lane octet assembly
  // ****************************************
  always_comb
  begin
    logic [31:0] word;
    logic [3:0][7:0] fl;
    logic [3:0] fk;
    logic [22:0] sres;
    logic [7:0] tpat;
    logic [1:0] src;
    logic [2:0] below;
    word = 32'h0000_0000;
    sres = 23'h000000;
    tpat = 8'h00;
    src = 2'h0;
    below = 3'h0;
    hold_nxt = sample_valid ? sample_data : hold_r;
    prev_nxt = sample_valid ? hold_r : prev_r;
    scr_nxt = scr_r;
    // Pattern counters restart whenever the source changes
    tsrc_nxt = test_source;
    tcnt_nxt = (st_r == ST_TEST && test_source == tsrc_r) ? tcnt_r + 8'h01 : 8'h00;
    once_nxt = (st_r == ST_TEST && test_source == tsrc_r) ? (once_r || tcnt_r[0]) : 1'b0;
    // repeat or oversample when no new sample
    if (sample_valid)
      word = sample_data;
    else if (!cfg_r.oversample_sel)
      word = hold_r;
    else
      for (int b = 0; b < 4; b++)
        word[b*8 +: 8] = 8'(({1'b0, hold_r[b*8 +: 8]} + {1'b0, prev_r[b*8 +: 8]}) >> 1);
    fl = '0;
    fk = 4'h0;
    for (int f = 0; f < 4; f++)
    begin
      below = 3'h0;
      for (int j = 0; j < f; j++)
        below = below + {2'b00, cfg_r.lane_enable_mask[j]};
      unique case (st_r)
        ST_CGS:
        begin
          fl[f] = `JTF_CHAR_K;
          fk[f] = 1'b1;
        end
        ST_ILAS:
        begin
          if (oct_r == 5'h00 && frm_r == 6'h00)
          begin
            fl[f] = `JTF_CHAR_R;
            fk[f] = 1'b1;
          end
          else if (mf_end)
          begin
            fl[f] = `JTF_CHAR_A;
            fk[f] = 1'b1;
          end
          else if (mfc_r == 3'h1 && frm_r == 6'h00 && oct_r == 5'h01)
          begin
            fl[f] = `JTF_CHAR_Q;
            fk[f] = 1'b1;
          end
          else if (mfc_r == 3'h1 && frm_r == 6'h01)
          begin
            unique case (oct_r[2:0])
              3'h0: fl[f] = cfg_r.link_device_ident;
              3'h1: fl[f] = {4'h0, cfg_r.link_bank_ident};
              3'h2: fl[f] = {3'h0, 5'(cfg_r.first_lane_ident + {2'b00, below})};
              3'h3: fl[f] = {7'h00, cfg_r.scramble_en};
              3'h4: fl[f] = {4'h0, cfg_r.converter_count};
              3'h5: fl[f] = {2'b00, cfg_r.frames_per_multiframe};
              3'h6: fl[f] = {3'h0, cfg_r.octets_per_frame};
              3'h7: fl[f] = {3'h0, cfg_r.bits_per_sample};
            endcase
          end
          else
            fl[f] = {3'h0, oct_r};
        end
        ST_DATA:
        begin
          fl[f] = word[f*8 +: 8];
          if (cfg_r.scramble_en && !cfg_r.link_standard_select)
          begin
            sres = scr8(scr_r[f], fl[f]);
            scr_nxt[f] = sres[22:8];
            fl[f] = sres[7:0];
          end
        end
        default: fl[f] = 8'h00;
      endcase
    end
    // 16-bit custom word once or repeated
    unique case (test_source)
      TS_CHECKER: tpat = `JTF_CHECKER;
      TS_TOGGLE: tpat = tcnt_r[0] ? `JTF_TOGGLE_HI : 8'h00;
      TS_RAMP: tpat = tcnt_r;
      TS_CUSTOM_PATTERN_REPEAT: tpat = tcnt_r[0] ? custom_pattern[7:0] : custom_pattern[15:8];
      TS_CUSTOM_PATTERN_SINGLE:
        tpat = (once_r || test_source != tsrc_r) ? 8'h00
            : (tcnt_r[0] ? custom_pattern[7:0] : custom_pattern[15:8]);
      default: tpat = prbs_oct;
    endcase
    for (int p = 0; p < 4; p++)
    begin
      src = cfg_r.manual_lane_route_en ? cfg_r.lane_route_map[p*2 +: 2] : 2'(p);
      out_nxt[p] = fl[src];
      ctl_nxt[p] = fk[src];
      if (st_r == ST_TEST)
      begin
        out_nxt[p] = tpat;
        ctl_nxt[p] = 1'b0;
      end
      if (!cfg_r.lane_enable_mask[p])
      begin
        out_nxt[p] = 8'h00;
        ctl_nxt[p] = 1'b0;
      end
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cfg_r <= '0;
      cfg_r.frames_per_multiframe <= `JTF_K_DEFAULT;
      cfg_r.octets_per_frame <= `JTF_F_DEFAULT;
      cfg_r.converter_count <= `JTF_M_DEFAULT;
      cfg_r.bits_per_sample <= `JTF_NP_DEFAULT;
      bad_r <= 1'b0;
      st_r <= ST_IDLE;
      iref_r <= 16'h0000;
      edge_r <= 4'h0;
      ref_seen_r <= 1'b0;
      relink_r <= 1'b0;
      oct_r <= 5'h00;
      frm_r <= 6'h00;
      mfc_r <= 3'h0;
      hold_r <= 32'h0000_0000;
      prev_r <= 32'h0000_0000;
      scr_r <= {4{`JTF_SCR_SEED}};
      tcnt_r <= 8'h00;
      once_r <= 1'b0;
      tsrc_r <= TS_NORMAL;
      out_r <= '0;
      ctl_r <= 4'h0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      bad_r <= bad_nxt;
      st_r <= st_nxt;
      iref_r <= iref_nxt;
      edge_r <= edge_nxt;
      ref_seen_r <= ref_seen_nxt;
      relink_r <= relink_nxt;
      oct_r <= oct_nxt;
      frm_r <= frm_nxt;
      mfc_r <= mfc_nxt;
      hold_r <= hold_nxt;
      prev_r <= prev_nxt;
      scr_r <= scr_nxt;
      tcnt_r <= tcnt_nxt;
      once_r <= once_nxt;
      tsrc_r <= tsrc_nxt;
      out_r <= out_nxt;
      ctl_r <= ctl_nxt;
    end
  end

  // PRBS source for test mode
  jtf_prbs_gen u_prbs (
    .mclk(mclk),
    .rst(rst),
    .run(st_r == ST_TEST),
    .order_sel(test_source),
    .prbs_octet(prbs_oct)
  );

  // Outputs
  assign lane_data = out_r;
  assign lane_is_ctrl = ctl_r;
  assign link_up = (st_r == ST_DATA);
  assign ref_locked = ref_seen_r;
  assign cfg_invalid = bad_r;

endmodule

`default_nettype wire

// *** jtf_framer_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "jtf_defs.svh"

module jtf_framer_monitor
  import jtf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic framer_init,
  input wire jtf_cfg_s cfg_in,
  input wire jtf_test_e test_source,
  input wire jtf_lanes_t lane_data,
  input wire logic [3:0] lane_is_ctrl,
  input wire logic link_up,
  input wire logic cfg_invalid
);
  wire logic cfg_ok;

  // Acceptance of an offered set
  assign cfg_ok = cfg_in.converter_count inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8}
    && cfg_in.frames_per_multiframe inside {[6'h01:6'h20]}
    && (cfg_in.octets_per_frame * cfg_in.frames_per_multiframe) % 4 == 0
    && cfg_in.octets_per_frame inside {5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10}
    && cfg_in.bits_per_sample inside {5'h0C, 5'h10, 5'h18}
    && cfg_in.multiframe_phase_offset < cfg_in.frames_per_multiframe
    && cfg_in.sync_request_input_sel != 2'h3;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Link, configuration and test data relations
  chk_cfg_verdict:
    assert property (framer_init |=> cfg_invalid == !$past(cfg_ok))
    else $error("wrong config verdict");
  chk_cfg_hold:
    assert property (!framer_init |=> $stable(cfg_invalid))
    else $error("config verdict moved");
  chk_init_drop:
    assert property (framer_init |=> !link_up)
    else $error("link up across init");
  chk_test_drop:
    assert property (test_source != TS_NORMAL |=> !link_up)
    else $error("link up in test mode");
  chk_test_plain:
    assert property ((test_source != TS_NORMAL) [*3] |-> lane_is_ctrl == 4'h0)
    else $error("control flag in test mode");
  chk_ctrl_chars:
    assert property (lane_is_ctrl[0] |-> lane_data[0] inside
      {`JTF_CHAR_K, `JTF_CHAR_R, `JTF_CHAR_A, `JTF_CHAR_Q})
    else $error("control flag on data octet");
  chk_checker_pat:
    assert property ((test_source == TS_CHECKER) [*3] |-> lane_data[0] inside
      {8'h00, `JTF_CHECKER})
    else $error("checkerboard octet wrong");
  chk_toggle_flip:
    assert property ((test_source == TS_TOGGLE) [*4] |->
      lane_data[0] == ~$past(lane_data[0])
      || (lane_data[0] == 8'h00 && $past(lane_data[0]) == 8'h00))
    else $error("toggle did not alternate");
endmodule

bind jtf_framer jtf_framer_monitor mon_u (
  .mclk(mclk),
  .rst(rst),
  .framer_init(framer_init),
  .cfg_in(cfg_in),
  .test_source(test_source),
  .lane_data(lane_data),
  .lane_is_ctrl(lane_is_ctrl),
  .link_up(link_up),
  .cfg_invalid(cfg_invalid)
);

`default_nettype wire

// *** jtf_far_model.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "jtf_defs.svh"

module jtf_far_model
  import jtf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire jtf_lanes_t lane_data,
  input wire logic [3:0] lane_is_ctrl,
  input wire logic drop_req,
  input wire logic prbs_clear,
  output logic sync_ok,
  output logic [15:0] prbs_errs
);
  logic [1:0] cgs_cnt_r;
  logic [6:0] hist_r;
  logic [7:0] pexp;

  // Expected PRBS7 octet from the bits already received
  always_comb
  begin
    logic [6:0] s;
    s = hist_r;
    pexp = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      pexp[i] = s[6] ^ s[5];
      s = {s[5:0], lane_data[0][i]};
    end
  end

  always_ff @(posedge mclk)
  begin
    hist_r <= lane_data[0][6:0];
    if (rst || prbs_clear)
      prbs_errs <= 16'h0000;
    else if (pexp != lane_data[0])
      prbs_errs <= prbs_errs + 16'h0001;
  end

  // Sync lifts after four code group octets on lane 0
  always_ff @(posedge mclk)
  begin
    if (rst || drop_req)
    begin
      cgs_cnt_r <= 2'h0;
      sync_ok <= 1'b0;
    end
    else if (lane_is_ctrl[0] && lane_data[0] == `JTF_CHAR_K)
    begin
      cgs_cnt_r <= cgs_cnt_r + 2'h1;
      sync_ok <= sync_ok || cgs_cnt_r == 2'h3;
    end
    else if (!sync_ok)
      cgs_cnt_r <= 2'h0;
  end
endmodule

`default_nettype wire

// *** jtf_framer_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "jtf_defs.svh"

module jtf_framer_tb
  import jtf_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic framer_init = 1'b0;
  jtf_cfg_s cfg = '0;
  logic sysref_ext_in = 1'b0;
  logic [31:0] sample_data = 32'h0;
  logic sample_valid = 1'b0;
  jtf_test_e test_source = TS_NORMAL;
  logic [15:0] custom_pattern = 16'hA53C;
  logic drop_req = 1'b0;
  logic prbs_clear = 1'b0;
  logic [15:0] prbs_errs;
  logic [2:0] sync_sel;
  logic [2:0] sync_single_in;
  logic [2:0] sync_diff_in;
  jtf_lanes_t lane_data;
  logic [3:0] lane_is_ctrl;
  logic link_up;
  logic ref_locked;
  logic cfg_invalid;
  logic sync_ok;
  int n_fail = 0;
  int cmp_count = 0;

  // Far side sync onto the selected pad only
  assign sync_sel = {3{sync_ok}} | ~(3'h1 << cfg.sync_request_input_sel);
  assign sync_single_in = cfg.sync_pad_differential_en ? 3'h7 : sync_sel;
  assign sync_diff_in = (cfg.sync_pad_differential_en ? sync_sel : 3'h7)
    ^ {3{cfg.sync_pad_polarity_inv}};

  // Clock
  initial
  begin
    forever
      #2.5 mclk = ~mclk;
  end

  jtf_framer dut_u (
    .mclk(mclk),
    .rst(rst),
    .framer_init(framer_init),
    .cfg_in(cfg),
    .sync_single_in(sync_single_in),
    .sync_diff_in(sync_diff_in),
    .sysref_ext_in(sysref_ext_in),
    .sample_data(sample_data),
    .sample_valid(sample_valid),
    .test_source(test_source),
    .custom_pattern(custom_pattern),
    .lane_data(lane_data),
    .lane_is_ctrl(lane_is_ctrl),
    .link_up(link_up),
    .ref_locked(ref_locked),
    .cfg_invalid(cfg_invalid)
  );

  jtf_far_model far_u (
    .mclk(mclk),
    .rst(rst),
    .lane_data(lane_data),
    .lane_is_ctrl(lane_is_ctrl),
    .drop_req(drop_req),
    .prbs_clear(prbs_clear),
    .sync_ok(sync_ok),
    .prbs_errs(prbs_errs)
  );

  // Compare and verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("Compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Bounded wait on link_up (0) or ref_locked (1)
  task automatic wait_flag(input bit sel, input logic val, input int lim);
    int i;
    for (i = 0; i < lim && (sel ? ref_locked : link_up) !== val; i++)
      @(posedge mclk);
    if (i == lim)
    begin
      n_fail++;
      $display("Error wait expected %h seen %h", val, ~val);
      results();
    end
  endtask

  task automatic init_link(input jtf_cfg_s c);
    cfg <= c;
    framer_init <= 1'b1;
    @(posedge mclk);
    framer_init <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic ref_pulse();
    sysref_ext_in <= 1'b1;
    repeat (4) @(posedge mclk);
    sysref_ext_in <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  // Reference model of set acceptance
  function automatic bit cfg_ok(input jtf_cfg_s c);
    int k;
    int f;
    k = c.frames_per_multiframe;
    f = c.octets_per_frame;
    return c.converter_count inside {0, 1, 2, 4, 8} && k inside {[1:32]} && f * k % 4 == 0
      && f inside {1, 2, 3, 4, 6, 8, 12, 16} && c.bits_per_sample inside {12, 16, 24}
      && c.multiframe_phase_offset < k && c.sync_request_input_sel != 3;
  endfunction

  // Routed, masked sample bytes per physical lane
  task automatic lanes_chk(input logic [31:0] w);
    int fl;
    repeat (6) @(posedge mclk);
    for (int p = 0; p < 4; p++)
    begin
      fl = cfg.manual_lane_route_en ? cfg.lane_route_map[2 * p +: 2] : p;
      chk("lane_data", cfg.lane_enable_mask[p] ? w[8 * fl +: 8] : 0,
        32'(lane_data[p]));
    end
  endtask

  // Main sequence
  initial
  begin
    jtf_cfg_s c;
    logic [95:0] r;
    logic [7:0] a;
    logic [7:0] b;
    int i;
    i = $urandom(84);
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 16; i++)
    begin
      r = {$urandom, $urandom, $urandom};
      c = jtf_cfg_s'(r[$bits(jtf_cfg_s)-1:0]);
      if (i % 2)
      begin
        c.converter_count = 4'h8;
        c.frames_per_multiframe = 6'h20;
        c.octets_per_frame = 5'h0C;
        c.bits_per_sample = 5'h18;
        c.multiframe_phase_offset = 5'h1F;
        c.sync_request_input_sel = 2'h1;
        case (i)
          3: c.octets_per_frame = 5'h05;
          7: c.frames_per_multiframe = 6'h1F;
          11: c.converter_count = 4'h3;
          15: c.bits_per_sample = 5'h14;
        endcase
      end
      init_link(c);
      chk("cfg_invalid", 32'(!cfg_ok(c)), 32'(cfg_invalid));
    end
    c = '0;
    c.converter_count = 4'h2;
    c.frames_per_multiframe = 6'h08;
    c.octets_per_frame = 5'h04;
    c.bits_per_sample = 5'h10;
    c.lane_enable_mask = 4'hD;
    c.lane_route_map = 8'h1B;
    c.manual_lane_route_en = 1'b1;
    c.multiframe_phase_offset = 5'h03;
    c.sync_request_input_sel = 2'h2;
    c.sync_pad_differential_en = 1'b1;
    c.sync_pad_polarity_inv = 1'b1;
    sample_data <= 32'hC4B3A291;
    sample_valid <= 1'b1;
    init_link(c);
    wait_flag(0, 1, 3000);
    lanes_chk(32'hC4B3A291);
    sample_valid <= 1'b0;
    lanes_chk(32'hC4B3A291);
    drop_req <= 1'b1;
    @(posedge mclk);
    drop_req <= 1'b0;
    wait_flag(0, 0, 12);
    wait_flag(0, 1, 3000);
    for (i = 1; i < 11; i++)
    begin
      test_source <= jtf_test_e'(i);
      prbs_clear <= 1'b1;
      repeat (8) @(posedge mclk);
      prbs_clear <= 1'b0;
      repeat (32) @(posedge mclk);
      a = lane_data[0];
      @(posedge mclk);
      b = lane_data[0];
      chk("link_up", 0, 32'(link_up));
      chk("lane_off", 0, 32'(lane_data[1]));
      case (i)
        1: chk("checker", `JTF_CHECKER, 32'(b));
        2: chk("toggle", {24'h0, ~a}, 32'(b));
        8: chk("ramp", {24'h0, a + 8'h1}, 32'(b));
        9: chk("custom", 32'(custom_pattern), a == custom_pattern[15:8] ? {a, b} : {b, a});
        10: chk("single", 0, 32'(b));
        default: chk("prbs", 1, 32'(a != b));
      endcase
      if (i == 7)
        chk("prbs_errs", 0, 32'(prbs_errs));
    end
    // Single pattern sent once after reselection
    test_source <= TS_CUSTOM_PATTERN_REPEAT;
    @(posedge mclk);
    test_source <= TS_CUSTOM_PATTERN_SINGLE;
    repeat (2) @(posedge mclk);
    repeat (4)
    begin
      @(posedge mclk);
      r = {r[87:0], lane_data[0]};
    end
    chk("single_seq", {custom_pattern, 16'h0000}, r[31:0]);
    test_source <= TS_NORMAL;
    wait_flag(0, 1, 3000);
    c.link_standard_select = 1'b1;
    c.sysref_source_sel = 1'b1;
    c.startup_ref_required = 1'b1;
    c.ref_edge_skip_en = 1'b1;
    c.ref_edge_select_count = 4'h2;
    c.oversample_sel = 1'b1;
    init_link(c);
    ref_pulse();
    ref_pulse();
    chk("ref_locked", 0, 32'(ref_locked));
    chk("link_up", 0, 32'(link_up));
    ref_pulse();
    chk("ref_locked", 1, 32'(ref_locked));
    wait_flag(0, 1, 200);
    // Bytewise mean of the last two words
    sample_data <= 32'h3C5A7E10;
    sample_valid <= 1'b1;
    @(posedge mclk);
    sample_valid <= 1'b0;
    lanes_chk(32'h80869050);
    results();
  end
endmodule

`default_nettype wire
